/* logic/sfst_pkg.sv */
// Package of register offsets, field positions and reset values for the fault status tree
//
// Operation
// - Global bit 7 is read-only, resets to 0, equals OR of vendor fault detail bits.
// - Global bit 2 is read-only OR of test and configuration-load fault detail bits.
// - Global bit 1 is read-only OR of control-status and communication fault detail bits.
// - Global bit 0 is read-only OR of the voltage-monitor summary register.
// - Global register at 10h; bits 7 to 3 reset to zero.
// - Summary bit 2 is OR of overvoltage flags; bits 7-3 and 1 read zero.
// - Summary bit 0 is OR of undervoltage flags; summary sits at 11h.
// - Undervoltage flags at 12h; bit n-1 sets when channel n falls below threshold.
// - A flag stays zero while its channel interrupt enable is off.
// - A set flag stays latched after the voltage recovers.
// - Write-one clears a flag only when its fault condition is gone.
// - After reset flags 8 to 5 are zero; flags 4 and 3 follow monitoring. Code resets all eight enables to one, so all flags follow monitoring.
// - Flags for channels 2 and 1 sit at bits 1 and 0, same behaviour.
// - Overvoltage flags at 16h set when channel rises above threshold, same latching.
package sfst_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_GLOBAL = 8'h10;
   localparam logic [7:0] OFS_SUMMARY = 8'h11;
   localparam logic [7:0] OFS_UV_FLAGS = 8'h12;
   localparam logic [7:0] OFS_OV_FLAGS = 8'h16;
   localparam logic [7:0] OFS_UV_ENABLE = 8'h18;
   localparam logic [7:0] OFS_OV_ENABLE = 8'h19;

   // ----------------------------------------------------------------
   // Field positions and widths
   // ----------------------------------------------------------------
   localparam int NUM_CHAN = 8;
   localparam int GBIT_VENDOR = 7;
   localparam int GBIT_TEST = 2;
   localparam int GBIT_CONTROL = 1;
   localparam int GBIT_MONITOR = 0;
   localparam int SBIT_OV = 2;
   localparam int SBIT_UV = 0;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_FLAGS = 8'h00;
   localparam logic [7:0] RST_ENABLE = 8'hFF;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

endpackage : sfst_pkg

/* logic/sfst_flag_bank.sv */
// Eight sticky fault flags with enable gating and conditional write-one clear
`timescale 1ns/1ps
module sfst_flag_bank (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Fault conditions and enables
   input wire logic [7:0] fault,
   input wire logic [7:0] enable,
   // Write-one clear request
   input wire logic clr_we,
   input wire logic [7:0] clr_data,
   // Flag state
   output logic [7:0] flags
);

   logic [7:0] flags_q;
   logic [7:0] flags_d;

   // Per-channel set, hold and clear
   for (genvar i = 0; i < sfst_pkg::NUM_CHAN; i++) begin : g_ch
      always_comb begin
         flags_d[i] = flags_q[i];
         if (clr_we && clr_data[i] && !fault[i]) begin
            flags_d[i] = 1'b0;
         end
         if (fault[i]) begin
            flags_d[i] = 1'b1;
         end
         if (!enable[i]) begin
            flags_d[i] = 1'b0;
         end
      end
   end

   // Flag storage
   always_ff @(posedge clk) begin
      if (rst) begin
         flags_q <= sfst_pkg::RST_FLAGS;
      end else begin
         flags_q <= flags_d;
      end
   end

   assign flags = flags_q;

   sequence s_clear_blocked;
      clr_we && (clr_data & flags_q & fault & enable) != 8'h00;
   endsequence

   chk_flag_latches: assert property (@(posedge clk) disable iff (rst)
      (flags_q & enable) != 8'h00 |=>
      ($past(flags_q & enable & ~(clr_data & ~fault & {8{clr_we}})) & ~flags_q) == 8'h00)
      else $error("flag lost");
   chk_flag_holds: assert property (@(posedge clk) disable iff (rst)
      s_clear_blocked |=> (flags_q & $past(clr_data & fault & enable))
      == $past(clr_data & fault & enable))
      else $error("flag cleared under fault");
   chk_flag_gated: assert property (@(posedge clk) disable iff (rst)
      (flags_q & ~$past(enable)) == 8'h00)
      else $error("disabled flag set");
   chk_flag_sets: assert property (@(posedge clk) disable iff (rst)
      (fault & enable) != 8'h00 |=> (flags_q & $past(fault & enable))
      == $past(fault & enable))
      else $error("flag not set");
   chk_flag_clears: assert property (@(posedge clk) disable iff (rst)
      clr_we && (clr_data & ~fault & flags_q) != 8'h00 |=>
      (flags_q & $past(clr_data & ~fault)) == 8'h00)
      else $error("clear ignored");

endmodule : sfst_flag_bank

/* logic/sfst_top.sv */
// Fault status tree: flags, summaries and Avalon-MM register slave
`timescale 1ns/1ps
module sfst_top (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // Avalon-MM slave
   input wire logic [7:0] ADDRESS,
   input wire logic READ,
   input wire logic WRITE,
   input wire logic [31:0] WRITEDATA,
   input wire logic [3:0] BYTEENABLE,
   output logic [31:0] READDATA,
   output logic WAITREQUEST,
   // Comparator fault conditions per channel
   input wire logic [7:0] UV_FAULT,
   input wire logic [7:0] OV_FAULT,
   // Other detail fault registers
   input wire logic [7:0] VENDOR_FAULTS,
   input wire logic [7:0] TEST_FAULTS,
   input wire logic [7:0] CONTROL_FAULTS,
   // Summary status
   output logic [7:0] GLOBAL_FAULT_SOURCE
);

   // ----------------------------------------------------------------
   // Bus access decode
   // ----------------------------------------------------------------
   logic ack_q;
   logic waitreq_q;
   logic [7:0] uv_enable_q;
   logic [7:0] ov_enable_q;
   logic [7:0] uv_flags;
   logic [7:0] ov_flags;
   logic [7:0] summary_q;
   logic [7:0] global_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic wr_take;
   logic lane0;

   // A request takes one wait cycle, then completes
   assign wr_take = WRITE && ack_q;
   assign lane0 = BYTEENABLE[0];

   // Handshake: waitrequest drops for one cycle per request
   always_ff @(posedge MCLK) begin
      if (RST) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (READ || WRITE) && !ack_q;
      end
   end

   // Waitrequest kept in its own flop so the pin carries no decode glitch
   always_ff @(posedge MCLK) begin
      if (RST) begin
         waitreq_q <= 1'b1;
      end else begin
         waitreq_q <= !((READ || WRITE) && !ack_q);
      end
   end

   assign WAITREQUEST = waitreq_q;

   // ----------------------------------------------------------------
   // Enable registers
   // ----------------------------------------------------------------
   // Software interrupt enables steer flag capture
   always_ff @(posedge MCLK) begin
      if (RST) begin
         uv_enable_q <= sfst_pkg::RST_ENABLE;
         ov_enable_q <= sfst_pkg::RST_ENABLE;
      end else if (wr_take && lane0) begin
         if (ADDRESS == sfst_pkg::OFS_UV_ENABLE) begin
            uv_enable_q <= WRITEDATA[7:0];
         end
         if (ADDRESS == sfst_pkg::OFS_OV_ENABLE) begin
            ov_enable_q <= WRITEDATA[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Flag banks
   // ----------------------------------------------------------------
   sfst_flag_bank u_uv (
      .clk(MCLK),
      .rst(RST),
      .fault(UV_FAULT),
      .enable(uv_enable_q),
      .clr_we(wr_take && lane0 && ADDRESS == sfst_pkg::OFS_UV_FLAGS),
      .clr_data(WRITEDATA[7:0]),
      .flags(uv_flags)
   );

   sfst_flag_bank u_ov (
      .clk(MCLK),
      .rst(RST),
      .fault(OV_FAULT),
      .enable(ov_enable_q),
      .clr_we(wr_take && lane0 && ADDRESS == sfst_pkg::OFS_OV_FLAGS),
      .clr_data(WRITEDATA[7:0]),
      .flags(ov_flags)
   );

   // ----------------------------------------------------------------
   // Summary levels
   // ----------------------------------------------------------------
   // Voltage monitor summary, reserved bits zero
   always_ff @(posedge MCLK) begin
      if (RST) begin
         summary_q <= sfst_pkg::RST_FLAGS;
      end else begin
         summary_q <= 8'h00;
         summary_q[sfst_pkg::SBIT_OV] <= |ov_flags;
         summary_q[sfst_pkg::SBIT_UV] <= |uv_flags;
      end
   end

   // Global source, fed from flag banks and detail registers
   always_ff @(posedge MCLK) begin
      if (RST) begin
         global_q <= sfst_pkg::RST_FLAGS;
      end else begin
         global_q <= 8'h00;
         global_q[sfst_pkg::GBIT_VENDOR] <= |VENDOR_FAULTS;
         global_q[sfst_pkg::GBIT_TEST] <= |TEST_FAULTS;
         global_q[sfst_pkg::GBIT_CONTROL] <= |CONTROL_FAULTS;
         global_q[sfst_pkg::GBIT_MONITOR] <= |(ov_flags | uv_flags);
      end
   end

   assign GLOBAL_FAULT_SOURCE = global_q;

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Read mux; unmapped addresses read zero
   always_comb begin
      rdata_d = sfst_pkg::RD_ZERO;
      unique case (ADDRESS)
         sfst_pkg::OFS_GLOBAL: rdata_d[7:0] = global_q;
         sfst_pkg::OFS_SUMMARY: rdata_d[7:0] = summary_q;
         sfst_pkg::OFS_UV_FLAGS: rdata_d[7:0] = uv_flags;
         sfst_pkg::OFS_OV_FLAGS: rdata_d[7:0] = ov_flags;
         sfst_pkg::OFS_UV_ENABLE: rdata_d[7:0] = uv_enable_q;
         sfst_pkg::OFS_OV_ENABLE: rdata_d[7:0] = ov_enable_q;
         default: rdata_d = sfst_pkg::RD_ZERO;
      endcase
   end

   // Read data registered, valid while waitrequest is low
   always_ff @(posedge MCLK) begin
      if (RST) begin
         rdata_q <= sfst_pkg::RD_ZERO;
      end else if (READ && !ack_q) begin
         rdata_q <= rdata_d;
      end
   end

   assign READDATA = rdata_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_vendor_summary: assert property (@(posedge MCLK) disable iff (RST)
      1'b1 |=> global_q[7] == |$past(VENDOR_FAULTS))
      else $error("vendor bit wrong");
   chk_test_summary: assert property (@(posedge MCLK) disable iff (RST)
      1'b1 |=> global_q[2] == |$past(TEST_FAULTS))
      else $error("test bit wrong");
   chk_control_summary: assert property (@(posedge MCLK) disable iff (RST)
      1'b1 |=> global_q[1] == |$past(CONTROL_FAULTS))
      else $error("control bit wrong");
   // Global monitor bit and summary are loaded on the same edge
   chk_monitor_tree: assert property (@(posedge MCLK) disable iff (RST)
      global_q[sfst_pkg::GBIT_MONITOR] == (summary_q != 8'h00))
      else $error("monitor bit wrong");
   // Reserved global bits never set
   chk_global_reserved: assert property (@(posedge MCLK) disable iff (RST)
      global_q[6:3] == 4'h0)
      else $error("global reserved set");
   chk_summary_bits: assert property (@(posedge MCLK) disable iff (RST)
      1'b1 |=> summary_q[2] == |$past(ov_flags) && summary_q[7:3] == 5'h00
      && !summary_q[1])
      else $error("summary wrong");
   chk_uv_summary: assert property (@(posedge MCLK) disable iff (RST)
      1'b1 |=> summary_q[0] == |$past(uv_flags))
      else $error("uv summary wrong");

   // ----------------------------------------------------------------
   // Bus handshake checks
   // ----------------------------------------------------------------
   // A request accepted while no completion is pending
   sequence s_req_taken;
      (READ || WRITE) && !ack_q;
   endsequence

   // A read accepted; its data is captured at this edge
   sequence s_read_taken;
      READ && !ack_q;
   endsequence

   // A write completing with the low byte lane enabled
   sequence s_write_done;
      WRITE && ack_q && lane0;
   endsequence

   // Every accepted request is answered after one wait state
   chk_wait_answer: assert property (@(posedge MCLK) disable iff (RST)
      s_req_taken |=> !WAITREQUEST)
      else $error("request not answered");

   // Waitrequest drops for a single cycle only
   chk_wait_single: assert property (@(posedge MCLK) disable iff (RST)
      !WAITREQUEST |=> WAITREQUEST)
      else $error("waitrequest low too long");

   // With no request on the bus waitrequest stays high
   chk_wait_idle: assert property (@(posedge MCLK) disable iff (RST)
      !(READ || WRITE) |=> WAITREQUEST)
      else $error("waitrequest low while idle");

   // The waitrequest flop stays in step with the completion flag
   chk_wait_track: assert property (@(posedge MCLK) disable iff (RST)
      WAITREQUEST == !ack_q)
      else $error("waitrequest out of step");

   // ----------------------------------------------------------------
   // Read path checks
   // ----------------------------------------------------------------
   // Upper byte lanes always read zero
   chk_read_upper: assert property (@(posedge MCLK) disable iff (RST)
      READDATA[31:8] == 24'h00_0000)
      else $error("upper read lanes set");

   // Global source read returns the register seen at acceptance
   chk_read_global: assert property (@(posedge MCLK) disable iff (RST)
      s_read_taken ##0 (ADDRESS == sfst_pkg::OFS_GLOBAL)
      |=> READDATA[7:0] == $past(global_q))
      else $error("global read wrong");

   // Summary read returns the summary register
   chk_read_summary: assert property (@(posedge MCLK) disable iff (RST)
      s_read_taken ##0 (ADDRESS == sfst_pkg::OFS_SUMMARY)
      |=> READDATA[7:0] == $past(summary_q))
      else $error("summary read wrong");

   // Undervoltage flag read returns the flag bank
   chk_read_uv: assert property (@(posedge MCLK) disable iff (RST)
      s_read_taken ##0 (ADDRESS == sfst_pkg::OFS_UV_FLAGS)
      |=> READDATA[7:0] == $past(uv_flags))
      else $error("uv flag read wrong");

   // Overvoltage flag read returns the flag bank
   chk_read_ov: assert property (@(posedge MCLK) disable iff (RST)
      s_read_taken ##0 (ADDRESS == sfst_pkg::OFS_OV_FLAGS)
      |=> READDATA[7:0] == $past(ov_flags))
      else $error("ov flag read wrong");

   // Undervoltage enable reads back
   chk_read_uv_en: assert property (@(posedge MCLK) disable iff (RST)
      s_read_taken ##0 (ADDRESS == sfst_pkg::OFS_UV_ENABLE)
      |=> READDATA[7:0] == $past(uv_enable_q))
      else $error("uv enable read wrong");

   // Overvoltage enable reads back
   chk_read_ov_en: assert property (@(posedge MCLK) disable iff (RST)
      s_read_taken ##0 (ADDRESS == sfst_pkg::OFS_OV_ENABLE)
      |=> READDATA[7:0] == $past(ov_enable_q))
      else $error("ov enable read wrong");

   // Addresses outside the map read zero
   chk_read_unmapped: assert property (@(posedge MCLK) disable iff (RST)
      s_read_taken ##0 (ADDRESS != sfst_pkg::OFS_GLOBAL && ADDRESS != sfst_pkg::OFS_SUMMARY
      && ADDRESS != sfst_pkg::OFS_UV_FLAGS && ADDRESS != sfst_pkg::OFS_OV_FLAGS
      && ADDRESS != sfst_pkg::OFS_UV_ENABLE && ADDRESS != sfst_pkg::OFS_OV_ENABLE)
      |=> READDATA == sfst_pkg::RD_ZERO)
      else $error("unmapped read not zero");

   // Read data stands until the next accepted read
   chk_read_hold: assert property (@(posedge MCLK) disable iff (RST)
      !(READ && !ack_q) |=> $stable(READDATA))
      else $error("read data moved");

   // ----------------------------------------------------------------
   // Write path checks
   // ----------------------------------------------------------------
   // Undervoltage enable takes the written byte
   chk_uv_en_write: assert property (@(posedge MCLK) disable iff (RST)
      s_write_done ##0 (ADDRESS == sfst_pkg::OFS_UV_ENABLE)
      |=> uv_enable_q == $past(WRITEDATA[7:0]))
      else $error("uv enable not written");

   // Overvoltage enable takes the written byte
   chk_ov_en_write: assert property (@(posedge MCLK) disable iff (RST)
      s_write_done ##0 (ADDRESS == sfst_pkg::OFS_OV_ENABLE)
      |=> ov_enable_q == $past(WRITEDATA[7:0]))
      else $error("ov enable not written");

   // Enables move only on a completed low-lane write
   chk_enable_stable: assert property (@(posedge MCLK) disable iff (RST)
      !(WRITE && ack_q && lane0)
      |=> $stable(uv_enable_q) && $stable(ov_enable_q))
      else $error("enable changed without write");

   // A one written to a fault-free undervoltage flag clears it
   chk_uv_clear_top: assert property (@(posedge MCLK) disable iff (RST)
      s_write_done ##0 (ADDRESS == sfst_pkg::OFS_UV_FLAGS)
      |=> (uv_flags & $past(WRITEDATA[7:0] & ~UV_FAULT)) == 8'h00)
      else $error("uv clear ignored");

   // A one written to a fault-free overvoltage flag clears it
   chk_ov_clear_top: assert property (@(posedge MCLK) disable iff (RST)
      s_write_done ##0 (ADDRESS == sfst_pkg::OFS_OV_FLAGS)
      |=> (ov_flags & $past(WRITEDATA[7:0] & ~OV_FAULT)) == 8'h00)
      else $error("ov clear ignored");

   // A present, enabled undervoltage fault survives a clear write
   chk_uv_fault_wins: assert property (@(posedge MCLK) disable iff (RST)
      s_write_done ##0 (ADDRESS == sfst_pkg::OFS_UV_FLAGS)
      |=> (uv_flags & $past(UV_FAULT & uv_enable_q)) == $past(UV_FAULT & uv_enable_q))
      else $error("uv flag cleared under fault");

   // ----------------------------------------------------------------
   // Reset checks
   // ----------------------------------------------------------------
   // Reset leaves every status register clear
   chk_reset_status: assert property (@(posedge MCLK)
      RST |=> global_q == sfst_pkg::RST_FLAGS && summary_q == sfst_pkg::RST_FLAGS
      && uv_flags == sfst_pkg::RST_FLAGS && ov_flags == sfst_pkg::RST_FLAGS)
      else $error("status not cleared by reset");

   // Reset opens all enables and parks the bus
   chk_reset_bus: assert property (@(posedge MCLK)
      RST |=> uv_enable_q == sfst_pkg::RST_ENABLE && ov_enable_q == sfst_pkg::RST_ENABLE
      && WAITREQUEST && READDATA == sfst_pkg::RD_ZERO)
      else $error("bus not parked by reset");

endmodule : sfst_top

/* bench/sfst_host_model.sv */
// Host model issuing Avalon-MM transfers to the fault status tree
`timescale 1ns/1ps
module sfst_host_model (
   // Clock
   input wire logic clk,
   // Avalon-MM master
   output logic [7:0] address,
   output logic read,
   output logic write,
   output logic [31:0] writedata,
   output logic [3:0] byteenable,
   input wire logic waitrequest
);
   // Bus idle from time zero
   initial begin
      address = 8'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0000_0000;
      byteenable = 4'h0;
   end

   // One transfer, held until waitrequest is sampled low
   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] be, output logic to);
      int n;
      begin
         @(posedge clk);
         address <= a;
         read <= ~wr;
         write <= wr;
         writedata <= d;
         byteenable <= be;
         to = 1'b1;
         for (n = 0; n < 20 && to; n++) begin
            @(posedge clk);
            if (waitrequest === 1'b0) to = 1'b0;
         end
         read <= 1'b0;
         write <= 1'b0;
      end
   endtask : xfer
endmodule : sfst_host_model

/* bench/sfst_tb_top.sv */
// Self-checking testbench of the fault status tree
`timescale 1ns/1ps
module sfst_tb_top;
   logic MCLK = 1'b0;
   logic RST = 1'b1;
   logic [7:0] UV_FAULT = 8'h00;
   logic [7:0] OV_FAULT = 8'h00;
   logic [7:0] VENDOR_FAULTS = 8'h00;
   logic [7:0] TEST_FAULTS = 8'h00;
   logic [7:0] CONTROL_FAULTS = 8'h00;
   logic [7:0] ADDRESS, GLOBAL_FAULT_SOURCE, r, p;
   logic READ, WRITE, WAITREQUEST;
   logic [31:0] WRITEDATA, READDATA;
   logic [3:0] BYTEENABLE;
   logic [31:0] exp_q[$];
   int num_errors = 0;
   int total_checks = 0;
   int seed = 69791;
   int i;

   // 40 MHz clock
   always #12.5 MCLK = ~MCLK;

   sfst_top uut (.MCLK(MCLK), .RST(RST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
      .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
      .WAITREQUEST(WAITREQUEST), .UV_FAULT(UV_FAULT), .OV_FAULT(OV_FAULT),
      .VENDOR_FAULTS(VENDOR_FAULTS), .TEST_FAULTS(TEST_FAULTS),
      .CONTROL_FAULTS(CONTROL_FAULTS), .GLOBAL_FAULT_SOURCE(GLOBAL_FAULT_SOURCE));
   sfst_host_model host (.clk(MCLK), .address(ADDRESS), .read(READ), .write(WRITE),
      .writedata(WRITEDATA), .byteenable(BYTEENABLE), .waitrequest(WAITREQUEST));

   // ----------------------------------------------------------------
   // Checking and closing
   // ----------------------------------------------------------------
   task check(input logic [31:0] got, input logic [31:0] want);
      begin
         total_checks++;
         if (got !== want) begin
            num_errors++;
            $display("[FAIL] %0t got %h want %h", $time, got, want);
         end
      end
   endtask : check

   task conclude;
      begin
         $display("checks %0d errors %0d", total_checks, num_errors);
         if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask : conclude

   // Read data compared against the oldest noted value
   always @(posedge MCLK) begin
      if (READ === 1'b1 && WAITREQUEST === 1'b0) begin
         if (exp_q.size() > 0) check(READDATA, exp_q.pop_front());
         else begin
            num_errors++;
            $display("[FAIL] %0t unexpected read", $time);
         end
      end
   end

   // Bus transfer; a read notes its expected data first
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] be = 4'hF);
      logic to;
      begin
         if (!wr) exp_q.push_back(d);
         host.xfer(wr, a, d, be, to);
         if (to) begin
            num_errors++;
            $display("[FAIL] %0t bus timeout", $time);
            conclude();
         end
      end
   endtask : bus

   // Summaries lag flags by at most two cycles
   task settle;
      repeat (4) @(posedge MCLK);
   endtask : settle

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge MCLK);
      RST <= 1'b0;
      bus(0, sfst_pkg::OFS_GLOBAL, 32'h0000_0000);
      bus(0, sfst_pkg::OFS_SUMMARY, 32'h0000_0000);
      bus(0, sfst_pkg::OFS_UV_FLAGS, 32'h0000_0000);
      bus(0, 8'h40, 32'h0000_0000);
      $display("test reset done");
      r = 8'($random(seed));
      r = r | 8'h83;
      p = r & 8'h7E;
      @(posedge MCLK);
      UV_FAULT <= r;
      settle();
      bus(0, sfst_pkg::OFS_UV_FLAGS, {24'h00_0000, r});
      bus(0, sfst_pkg::OFS_SUMMARY, 32'h0000_0001);
      check({24'h00_0000, GLOBAL_FAULT_SOURCE}, 32'h0000_0001);
      @(posedge MCLK);
      UV_FAULT <= p;
      settle();
      bus(0, sfst_pkg::OFS_UV_FLAGS, {24'h00_0000, r});
      bus(1, sfst_pkg::OFS_UV_FLAGS, 32'h0000_0000);
      bus(1, sfst_pkg::OFS_UV_FLAGS, 32'h0000_00FF, 4'h0);
      bus(1, sfst_pkg::OFS_SUMMARY, 32'h0000_00FF);
      bus(0, sfst_pkg::OFS_UV_FLAGS, {24'h00_0000, r});
      bus(1, sfst_pkg::OFS_UV_FLAGS, 32'h0000_00FF);
      bus(0, sfst_pkg::OFS_UV_FLAGS, {24'h00_0000, p});
      @(posedge MCLK);
      UV_FAULT <= 8'h00;
      bus(1, sfst_pkg::OFS_UV_FLAGS, 32'h0000_00FF);
      bus(0, sfst_pkg::OFS_UV_FLAGS, 32'h0000_0000);
      $display("test sticky flags done");
      bus(1, sfst_pkg::OFS_UV_ENABLE, 32'h0000_0000);
      @(posedge MCLK);
      UV_FAULT <= 8'hFF;
      settle();
      bus(0, sfst_pkg::OFS_UV_FLAGS, 32'h0000_0000);
      bus(1, sfst_pkg::OFS_UV_ENABLE, 32'h0000_000F);
      bus(0, sfst_pkg::OFS_UV_ENABLE, 32'h0000_000F);
      settle();
      bus(0, sfst_pkg::OFS_UV_FLAGS, 32'h0000_000F);
      $display("test enable done");
      @(posedge MCLK);
      OV_FAULT <= 8'h80;
      settle();
      bus(0, sfst_pkg::OFS_OV_FLAGS, 32'h0000_0080);
      bus(0, sfst_pkg::OFS_SUMMARY, 32'h0000_0005);
      @(posedge MCLK);
      OV_FAULT <= 8'h00;
      settle();
      bus(0, sfst_pkg::OFS_OV_FLAGS, 32'h0000_0080);
      bus(1, sfst_pkg::OFS_OV_ENABLE, 32'h0000_007F);
      bus(0, sfst_pkg::OFS_OV_ENABLE, 32'h0000_007F);
      bus(0, sfst_pkg::OFS_OV_FLAGS, 32'h0000_0000);
      $display("test overvoltage done");
      for (i = 0; i < 3; i++) begin
         r = 8'($random(seed));
         r = r | 8'h01;
         @(posedge MCLK);
         VENDOR_FAULTS <= (i == 0) ? r : 8'h00;
         TEST_FAULTS <= (i == 1) ? r : 8'h00;
         CONTROL_FAULTS <= (i == 2) ? r : 8'h00;
         settle();
         p = (i == 0) ? 8'h81 : (i == 1) ? 8'h05 : 8'h03;
         check({24'h00_0000, GLOBAL_FAULT_SOURCE}, {24'h00_0000, p});
         bus(0, sfst_pkg::OFS_GLOBAL, {24'h00_0000, p});
      end
      $display("test global source done");
      settle();
      check(exp_q.size(), 32'h0000_0000);
      conclude();
   end
endmodule : sfst_tb_top
